// file: srbp_map.svh
// constants of the status register one and block protection logic
//
// Overview of operation
// - status one is written by write-status or write-any, read by read commands
// - write-any at register address 0x000000 writes the non-volatile copy
// - write-any at register address 0x070000 writes only the volatile copy
// - read-any returns status one at address 0x000000 or 0x070000
// - bit7 lock, bit6 reserved, bit5 top/bottom, bits4:2 protect, bit1 latch, bit0 busy
// - lock, selector, protect bits exist twice and are writable; latch, busy read-only
// - every status one bit defaults to zero
// - lock set with write-protect pin low ignores all register writes
// - lock clear means no register write protection, whatever the pin level
// - write enable latch reads zero after power-up; one means writes enabled
// - nonzero protect field refuses array writes inside the selected range
// - selector zero anchors the range at the top, one at the bottom
// - top ranges: none, 1/64 up to half, then full; 001 is 0x07E000-0x07FFFF
// - bottom ranges: none, 1/64 up to half, then full; 001 is 0x000000-0x001FFF
// - every status one read returns the volatile copy
// - a non-volatile write updates both copies at once
// - only the write-enable command sets the write enable latch
// - writes need the latch set; with it clear they are treated as protected
`ifndef SRBP_MAP_SVH
`define SRBP_MAP_SVH

// ----------------------------------------------------------------
// opcodes and register addresses
// ----------------------------------------------------------------
`define SRBP_OP_WR_DISABLE 8'h04
`define SRBP_OP_WR_STATUS  8'h01
`define SRBP_OP_WR_ANY     8'h71
`define SRBP_ADDR_NV       24'h00_0000
`define SRBP_ADDR_VOL      24'h07_0000

// ----------------------------------------------------------------
// status one field positions and values
// ----------------------------------------------------------------
`define SRBP_BIT_LOCK 7
`define SRBP_BIT_RSVD 6
`define SRBP_BIT_TB   5
`define SRBP_BP_HI    4
`define SRBP_BP_LO    2
`define SRBP_BIT_LATCH 1
`define SRBP_BIT_BUSY 0
`define SRBP_WR_MASK  8'hbc
`define SRBP_RST_VAL  8'h00

// ----------------------------------------------------------------
// frame lengths in link clock edges
// ----------------------------------------------------------------
`define SRBP_LEN_OP   6'h08
`define SRBP_LEN_STAT 6'h10
`define SRBP_LEN_ADDR 6'h20
`define SRBP_LEN_ANY  6'h28
`define SRBP_CNT_MAX  6'h3f

// ----------------------------------------------------------------
// array geometry: smallest range is 2^(base+1) bytes
// ----------------------------------------------------------------
`define SRBP_AW        19
`define SRBP_SIZE_BASE 5'h0c

`endif

// file: srbp_pkg.sv
// types shared by the status register one modules
package srbp_pkg;

    typedef logic [7:0] srbp_byte_t;

    typedef enum logic [1:0] {
        st_idle   = 2'b00,
        st_frame  = 2'b01,
        st_commit = 2'b11
    } srbp_state_e;

    typedef struct packed {
        srbp_state_e st;
        logic        cs_m;
        logic        cs_q;
        logic        wp_m;
        logic        wp_q;
        srbp_byte_t  vol;
        srbp_byte_t  nv;
        logic        wen;
        srbp_byte_t  snap;
        srbp_byte_t  stat;
        logic        cfg_ok;
        logic        chk_done;
        logic        chk_allow;
    } srbp_top_s;

    typedef struct packed {
        logic [39:0] sh;
        logic [5:0]  cnt;
    } srbp_link_s;

    typedef struct packed {
        srbp_byte_t obuf;
        logic       so;
        logic       oe;
    } srbp_out_s;

endpackage

// file: srbp_frame_if.sv
// frame words between the link logic and the core
`timescale 1ns/1ns
`default_nettype none
interface srbp_frame_if;
    logic [39:0] sh;
    logic [5:0]  cnt;
    logic [7:0]  snap;

    modport link (output sh, output cnt, input snap);
    modport core (input sh, input cnt, output snap);
endinterface
`default_nettype wire

// file: srbp_range.sv
// protected address range decode
`include "srbp_map.svh"
`timescale 1ns/1ns
`default_nettype none
module srbp_range #(
    parameter int AW = `SRBP_AW
)(
    // protect settings
    input  wire logic          tb_i,
    input  wire logic [2:0]    bp_i,
    // address under test
    input  wire logic [AW-1:0] addr_i,
    output logic               prot_o
);
    import srbp_pkg::*;

    logic [AW-1:0] mask;
    logic [4:0]    sh_amt;

    // nonzero code k covers 2^(base+k) bytes; code 7 zeroes the mask, so all is protected
    always_comb begin
        sh_amt = `SRBP_SIZE_BASE + {2'b00, bp_i};
        mask   = {AW{1'b1}} << sh_amt;
        if (bp_i == 3'h0) begin
            prot_o = 1'b0;
        end else if (tb_i) begin
            prot_o = ((addr_i & mask) == '0);
        end else begin
            prot_o = ((addr_i & mask) == mask);
        end
    end
endmodule
`default_nettype wire

// file: srbp_link.sv
// serial link side: shift in frames, drive read data
`include "srbp_map.svh"
`timescale 1ns/1ns
`default_nettype none
module srbp_link #(
    parameter logic [7:0] OP_RD_STATUS = 8'h05,
    parameter logic [7:0] OP_RD_ANY    = 8'h65
)(
    // link pins
    input  wire logic sck_i,
    input  wire logic cs_n_i,
    input  wire logic si_i,
    input  wire logic rst_i,
    output logic      so_o,
    output logic      so_oe_o,
    // frame words to the core
    srbp_frame_if.link f
);
    import srbp_pkg::*;

    srbp_link_s r;
    srbp_link_s n;
    srbp_out_s  o;
    srbp_out_s  on;
    logic       armed_r;
    logic       rd_one;
    logic       rd_any;

    // ------------------------------------------------------------
    // input shifter
    // ------------------------------------------------------------
    // sck stands still between frames, so the frame start is armed by cs
    always_ff @(posedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            armed_r <= 1'b1;
        end else begin
            armed_r <= 1'b0;
        end
    end

    always_comb begin
        n    = r;
        n.sh = {r.sh[38:0], si_i};
        if (armed_r) begin
            n.cnt = 6'h01;
        end else if (r.cnt != `SRBP_CNT_MAX) begin
            n.cnt = r.cnt + 6'h01;
        end
    end

    // count and words survive cs rising; the core reads them then
    always_ff @(posedge sck_i or posedge rst_i) begin
        if (rst_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign f.sh  = r.sh;
    assign f.cnt = r.cnt;

    // ------------------------------------------------------------
    // read data, launched on the falling edge
    // ------------------------------------------------------------
    always_comb begin
        rd_one = (r.cnt == `SRBP_LEN_OP) && (r.sh[7:0] == OP_RD_STATUS);
        rd_any = (r.cnt == `SRBP_LEN_ADDR) && (r.sh[31:24] == OP_RD_ANY)
              && ((r.sh[23:0] == `SRBP_ADDR_NV)
              ||  (r.sh[23:0] == `SRBP_ADDR_VOL));
        on      = o;
        on.so   = o.obuf[7];
        on.obuf = {o.obuf[6:0], 1'b0};
        if (rd_one || rd_any) begin
            on.so   = f.snap[7];
            on.obuf = {f.snap[6:0], 1'b0};
            on.oe   = 1'b1;
        end
    end

    always_ff @(negedge sck_i or posedge cs_n_i or posedge rst_i) begin
        if (cs_n_i || rst_i) begin
            o <= '0;
        end else begin
            o <= on;
        end
    end

    assign so_o    = o.so;
    assign so_oe_o = o.oe;
endmodule
`default_nettype wire

// file: srbp_top.sv
// status register one with array block protection
`include "srbp_map.svh"
`timescale 1ns/1ns
`default_nettype none
module srbp_top #(
    parameter logic [7:0] OP_WR_ENABLE = 8'h06,
    parameter logic [7:0] OP_RD_STATUS = 8'h05,
    parameter logic [7:0] OP_RD_ANY    = 8'h65,
    parameter int         AW           = `SRBP_AW
)(
    // system clock and reset
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    // serial link pins
    input  wire logic          sck_i,
    input  wire logic          cs_n_i,
    input  wire logic          si_i,
    input  wire logic          wp_n_i,
    output logic               so_o,
    output logic               so_oe_o,
    // device events and status
    input  wire logic          busy_i,
    input  wire logic          reload_i,
    output var srbp_pkg::srbp_byte_t status_o,
    output var srbp_pkg::srbp_byte_t status_nv_o,
    output logic               cfg_write_ok_o,
    // array write check
    input  wire logic          chk_valid_i,
    input  wire logic [AW-1:0] chk_addr_i,
    output logic               chk_done_o,
    output logic               chk_allow_o
);
    import srbp_pkg::*;

    srbp_top_s  r;
    srbp_top_s  n;
    srbp_byte_t rd_val;
    srbp_byte_t wdata;
    logic [23:0] waddr;
    logic       commit;
    logic       is_enab;
    logic       is_disa;
    logic       is_stwr;
    logic       is_anwr;
    logic       lock_on;
    logic       reg_ok;
    logic       wr_nv;
    logic       wr_vol;
    logic       enab_go;
    logic       prot;

    srbp_frame_if f ();

    // ------------------------------------------------------------
    // link side and range decode
    // ------------------------------------------------------------
    srbp_link #(
        .OP_RD_STATUS (OP_RD_STATUS),
        .OP_RD_ANY    (OP_RD_ANY)
    ) u_link (
        .sck_i   (sck_i),
        .cs_n_i  (cs_n_i),
        .si_i    (si_i),
        .rst_i   (rst_i),
        .so_o    (so_o),
        .so_oe_o (so_oe_o),
        .f       (f.link)
    );

    srbp_range #(
        .AW (AW)
    ) u_range (
        .tb_i   (r.vol[`SRBP_BIT_TB]),
        .bp_i   (r.vol[`SRBP_BP_HI:`SRBP_BP_LO]),
        .addr_i (chk_addr_i),
        .prot_o (prot)
    );

    // snapshot changes only between frames, so the link reads it settled
    assign f.snap = r.snap;

    // ------------------------------------------------------------
    // command decode, valid only in the commit state
    // ------------------------------------------------------------
    always_comb begin
        commit  = (r.st == st_commit);
        wdata   = f.sh[7:0];
        waddr   = f.sh[31:8];
        is_enab = (f.cnt == `SRBP_LEN_OP) && (f.sh[7:0] == OP_WR_ENABLE);
        is_disa = (f.cnt == `SRBP_LEN_OP)
               && (f.sh[7:0] == `SRBP_OP_WR_DISABLE);
        is_stwr = (f.cnt == `SRBP_LEN_STAT)
               && (f.sh[15:8] == `SRBP_OP_WR_STATUS);
        is_anwr = (f.cnt == `SRBP_LEN_ANY)
               && (f.sh[39:32] == `SRBP_OP_WR_ANY);
        lock_on = r.vol[`SRBP_BIT_LOCK] && !r.wp_q;
        reg_ok  = r.wen && !lock_on;
        wr_nv   = commit && !busy_i && reg_ok
               && (is_stwr || (is_anwr && waddr == `SRBP_ADDR_NV));
        wr_vol  = wr_nv || (commit && !busy_i && reg_ok && is_anwr
               && waddr == `SRBP_ADDR_VOL);
        enab_go = commit && !busy_i && is_enab;
        // reserved bit always reads zero through the mask
        rd_val  = (r.vol & `SRBP_WR_MASK)
                | {6'h00, r.wen, busy_i};
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        n      = r;
        n.cs_m = cs_n_i;
        n.cs_q = r.cs_m;
        n.wp_m = wp_n_i;
        n.wp_q = r.wp_m;
        case (r.st)
            st_idle: begin
                if (!r.cs_q) begin
                    n.st = st_frame;
                end
            end
            st_frame: begin
                if (r.cs_q) begin
                    n.st = st_commit;
                end
            end
            st_commit: begin
                n.st = st_idle;
            end
            default: begin
                n.st = st_idle;
            end
        endcase
        if (r.st == st_idle && r.cs_q) begin
            n.snap = rd_val;
        end
        // a hardware reset event reloads the working copy
        if (reload_i) begin
            n.vol = r.nv;
            n.wen = 1'b0;
        end
        // busy ignores every command except the reads, which the link still serves
        if (commit && !busy_i) begin
            if (is_stwr || is_anwr || is_disa) begin
                n.wen = 1'b0;
            end
            if (is_enab) begin
                n.wen = 1'b1;
            end
        end
        if (wr_vol) begin
            n.vol = wdata & `SRBP_WR_MASK;
        end
        if (wr_nv) begin
            n.nv = wdata & `SRBP_WR_MASK;
        end
        n.stat   = rd_val;
        n.cfg_ok = reg_ok && !busy_i;
        n.chk_done = chk_valid_i;
        if (chk_valid_i) begin
            n.chk_allow = r.wen && !busy_i && !prot;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r       <= '0;
            r.cs_m  <= 1'b1;
            r.cs_q  <= 1'b1;
            r.vol   <= `SRBP_RST_VAL;
            r.nv    <= `SRBP_RST_VAL;
        end else begin
            r <= n;
        end
    end

    assign status_o       = r.stat;
    assign status_nv_o    = r.nv;
    assign cfg_write_ok_o = r.cfg_ok;
    assign chk_done_o     = r.chk_done;
    assign chk_allow_o    = r.chk_allow;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_frame_close;
        (r.st == st_frame) && r.cs_q;
    endsequence

    sequence s_commit_then_idle;
        (r.st == st_commit) ##1 (r.st == st_idle);
    endsequence

    sequence s_open_write;
        commit && !busy_i && r.wen && !lock_on;
    endsequence

    property p_frame_commit;
        s_frame_close |=> s_commit_then_idle;
    endproperty

    frame_commit_a: assert property (p_frame_commit)
        else $error("frame end did not reach commit");

    latch_set_a: assert property (enab_go |=> r.wen)
        else $error("write enable command did not set latch");

    latch_cause_a: assert property ($rose(r.wen) |-> $past(enab_go))
        else $error("latch set without write enable command");

    lock_hold_a: assert property (
        commit && (is_stwr || is_anwr) && lock_on
        |=> $stable(r.vol) && $stable(r.nv))
        else $error("locked register was written");

    unlock_write_a: assert property (
        s_open_write ##0 is_stwr && !reload_i
        |=> r.vol == ($past(wdata) & `SRBP_WR_MASK) && r.nv == r.vol)
        else $error("unlocked status write lost");

    any_nv_a: assert property (
        s_open_write ##0 is_anwr && waddr == `SRBP_ADDR_NV
        |=> r.nv == r.vol && r.nv == ($past(wdata) & `SRBP_WR_MASK))
        else $error("non-volatile write did not update both copies");

    any_vol_a: assert property (
        s_open_write ##0 is_anwr && waddr == `SRBP_ADDR_VOL
        |=> $stable(r.nv) && r.vol == ($past(wdata) & `SRBP_WR_MASK))
        else $error("volatile write touched non-volatile copy");

    no_latch_write_a: assert property (
        commit && (is_stwr || is_anwr) && !r.wen && !reload_i
        |=> $stable(r.vol) && !r.wen)
        else $error("register written with latch clear");

    reserved_zero_a: assert property (
        !status_o[`SRBP_BIT_RSVD] && (r.nv & ~`SRBP_WR_MASK) == 8'h00)
        else $error("reserved or read-only bit stored");

    reset_zero_a: assert property (
        $fell(rst_i) |-> !r.wen && r.vol == `SRBP_RST_VAL)
        else $error("status not zero after reset");

    chk_deny_a: assert property (
        chk_valid_i && (!r.wen || prot) |=> chk_done_o && !chk_allow_o)
        else $error("protected array write allowed");

    chk_top_a: assert property (
        chk_valid_i && r.wen && !busy_i && !r.vol[`SRBP_BIT_TB]
        && r.vol[`SRBP_BP_HI:`SRBP_BP_LO] == 3'h1
        |=> chk_allow_o == ($past(chk_addr_i) < 19'h7_e000))
        else $error("top 1/64 range decoded wrong");

    chk_bot_a: assert property (
        chk_valid_i && r.wen && !busy_i && r.vol[`SRBP_BIT_TB]
        && r.vol[`SRBP_BP_HI:`SRBP_BP_LO] == 3'h1
        |=> chk_allow_o == ($past(chk_addr_i) > 19'h0_1fff))
        else $error("bottom 1/64 range decoded wrong");

    snap_freeze_a: assert property (
        (r.st != st_idle) |=> $stable(r.snap))
        else $error("read snapshot moved during frame");
endmodule
`default_nettype wire

// file: srbp_host.sv
// serial host model that drives frames onto the device link pins
`timescale 1ns/1ns
`default_nettype none
module srbp_host (
    // link pins toward the device
    output logic      sck_o,
    output logic      cs_n_o,
    output logic      si_o,
    // read data back
    input  wire logic so_i,
    input  wire logic so_oe_i
);
    initial begin
        sck_o  = 1'b0;
        cs_n_o = 1'b1;
        si_o   = 1'b0;
    end

    // ------------------------------------------------
    // one frame: n bits msb first, last 8 bits back
    // ------------------------------------------------
    // clock stands low between frames; odd start offset keeps
    // the link edges away from the system clock edges
    task automatic xfer(input logic [39:0] b, input int n,
                        output logic [7:0] rd);
        rd = 8'h00;
        #13;
        cs_n_o = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            si_o = b[i];
            #40;
            sck_o = 1'b1;
            rd = {rd[6:0], so_oe_i ? so_i : 1'bx};
            #40;
            sck_o = 1'b0;
        end
        // released line: never leave the last bit standing
        si_o = ~si_o;
        #40;
        cs_n_o = 1'b1;
        #40;
    endtask
endmodule
`default_nettype wire

// file: tb.sv
// self-checking bench for status one and block protection
`include "srbp_map.svh"
`timescale 1ns/1ns
`default_nettype none
module tb;
    import srbp_pkg::*;

    localparam logic [7:0] OP_WR_EN  = 8'h06;
    localparam logic [7:0] OP_RDSR   = 8'h05;
    localparam logic [7:0] OP_RD_ANY = 8'h65;
    localparam int         LIMIT   = 80000;

    logic        clk_i;
    logic        rst_i;
    logic        wp_n_i;
    logic        busy_i;
    logic        reload_i;
    logic        chk_valid_i;
    logic [18:0] chk_addr_i;
    wire logic   sck;
    wire logic   cs_n;
    wire logic   si;
    wire logic   so;
    wire logic   so_oe;
    wire logic   cfg_ok;
    srbp_byte_t  status_o;
    srbp_byte_t  status_nv_o;
    logic        chk_done;
    logic        chk_allow;
    int          n_mismatch;
    int          n_checks;
    int          cycles;
    logic [7:0]  rd;
    logic [3:0]  cfg;
    logic [19:0] size;
    logic        en_exp;

    srbp_host host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si),
                    .so_i(so), .so_oe_i(so_oe));

    srbp_top #(.OP_WR_ENABLE(OP_WR_EN), .OP_RD_STATUS(OP_RDSR),
               .OP_RD_ANY(OP_RD_ANY)) DUT (
        .clk_i(clk_i), .rst_i(rst_i), .sck_i(sck), .cs_n_i(cs_n),
        .si_i(si), .wp_n_i(wp_n_i), .so_o(so), .so_oe_o(so_oe),
        .busy_i(busy_i), .reload_i(reload_i), .status_o(status_o),
        .status_nv_o(status_nv_o), .cfg_write_ok_o(cfg_ok),
        .chk_valid_i(chk_valid_i), .chk_addr_i(chk_addr_i),
        .chk_done_o(chk_done), .chk_allow_o(chk_allow));

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // ------------------------------------------------
    // reporting
    // ------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    // ------------------------------------------------
    // frames and expectations
    // ------------------------------------------------
    task automatic idle(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // settle time covers sync, commit and status register
    task automatic frame(input logic [39:0] b, input int n);
        host.xfer(b, n, rd);
        idle(10);
    endtask

    task automatic set_wen();
        frame({32'h0000_0000, OP_WR_EN}, 8);
    endtask

    task automatic wr_sr(input logic [7:0] d);
        frame({24'h00_0000, `SRBP_OP_WR_STATUS, d}, 16);
    endtask

    task automatic wr_any(input logic [23:0] a, input logic [7:0] d);
        frame({`SRBP_OP_WR_ANY, a, d}, 40);
    endtask

    task automatic rd_any(input logic [23:0] a);
        frame({OP_RD_ANY, a, 8'h00}, 40);
    endtask

    function automatic logic prot(input logic [3:0] c,
                                  input logic [18:0] a);
        logic [19:0] sz;
        sz = 20'h0_1000 << c[2:0];
        if (c[2:0] == 3'h0) return 1'b0;
        if (c[3]) return {1'b0, a} < sz;
        return {1'b0, a} >= 20'h8_0000 - sz;
    endfunction

    // valid stays high across back-to-back probes
    task automatic probe(input logic [18:0] a, input logic [3:0] c);
        chk_addr_i  = a;
        chk_valid_i = 1'b1;
        @(negedge clk_i);
        chk(chk_done, 1'b1);
        chk(chk_allow, en_exp && !prot(c, a));
    endtask

    // ------------------------------------------------
    // main sequence
    // ------------------------------------------------
    initial begin
        n_mismatch  = 0;
        n_checks    = 0;
        cycles      = 0;
        rst_i       = 1'b1;
        wp_n_i      = 1'b1;
        busy_i      = 1'b0;
        reload_i    = 1'b0;
        chk_valid_i = 1'b0;
        chk_addr_i  = 19'h0_0000;
        en_exp      = 1'b1;
        rd = 8'($urandom(32'h7b27_3030));
        idle(8);
        rst_i = 1'b0;
        idle(4);
        chk(status_o, 8'h00);
        chk(status_nv_o, 8'h00);
        frame({24'h00_0000, OP_RDSR, 8'h00}, 16);
        chk(rd, 8'h00);
        set_wen();
        chk(status_o, 8'h02);
        chk(cfg_ok, 1'b1);
        frame({24'h00_0000, OP_RDSR, 8'h00}, 16);
        chk(rd, 8'h02);
        wr_sr(8'hff);
        chk(status_o, 8'hbc);
        chk(status_nv_o, 8'hbc);
        rd_any(`SRBP_ADDR_NV);
        chk(rd, 8'hbc);
        rd_any(`SRBP_ADDR_VOL);
        chk(rd, 8'hbc);
        wr_sr(8'h00);
        chk(status_o, 8'hbc);
        set_wen();
        wr_any(`SRBP_ADDR_VOL, 8'h24);
        chk(status_o, 8'h24);
        chk(status_nv_o, 8'hbc);
        rd_any(`SRBP_ADDR_NV);
        chk(rd, 8'h24);
        reload_i = 1'b1;
        idle(1);
        reload_i = 1'b0;
        idle(3);
        chk(status_o, 8'hbc);
        set_wen();
        wr_any(`SRBP_ADDR_NV, 8'h80);
        chk(status_nv_o, 8'h80);
        chk(status_o, 8'h80);
        // lock set, pin low: writes dropped, latch still cleared
        wp_n_i = 1'b0;
        idle(4);
        set_wen();
        chk(cfg_ok, 1'b0);
        wr_sr(8'h00);
        chk(status_o, 8'h80);
        set_wen();
        wr_any(`SRBP_ADDR_VOL, 8'h00);
        chk(status_o, 8'h80);
        wp_n_i = 1'b1;
        idle(4);
        set_wen();
        wr_any(`SRBP_ADDR_VOL, 8'h00);
        chk(status_o, 8'h00);
        wp_n_i = 1'b0;
        idle(4);
        set_wen();
        wr_sr(8'h1c);
        chk(status_o, 8'h1c);
        wp_n_i = 1'b1;
        busy_i = 1'b1;
        idle(2);
        chk(status_o, 8'h1d);
        set_wen();
        chk(status_o, 8'h1d);
        busy_i = 1'b0;
        idle(2);
        // every selector and protect code, then random ones
        for (int k = 0; k < 20; k++) begin
            cfg  = (k < 16) ? 4'(k) : 4'($urandom);
            size = 20'h0_1000 << cfg[2:0];
            set_wen();
            wr_any(`SRBP_ADDR_VOL, {2'b00, cfg, 2'b00});
            set_wen();
            chk(status_o, {2'b00, cfg, 2'b10});
            probe(19'(size - 20'h0_0001), cfg);
            probe(19'(size), cfg);
            probe(19'(20'h8_0000 - size), cfg);
            probe(19'(20'h7_ffff - size), cfg);
            probe(19'($urandom), cfg);
            chk_valid_i = 1'b0;
            idle(2);
        end
        frame({32'h0000_0000, `SRBP_OP_WR_DISABLE}, 8);
        chk(status_o[1], 1'b0);
        en_exp = 1'b0;
        probe(19'h0_0000, 4'h0);
        chk_valid_i = 1'b0;
        chk(chk_allow, 1'b0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
